// ===== rtl/ebt_pkg.sv
// shared constants, register map and types of the eight-bit reload timer
package ebt_pkg;

  // ---------------------------------------------------------------------------
  // counter and prescaler
  // ---------------------------------------------------------------------------
  localparam int          CNT_W        = 8;
  localparam logic [7:0]  COUNT_MAX    = 8'hFF;
  localparam logic [7:0]  COUNT_RST    = 8'h00;
  localparam logic [7:0]  RELOAD_RST   = 8'h00;
  localparam int          PRE_W        = 13;
  localparam int          N_TAPS       = 7;
  // log2 of the divisors 4,16,64,256,512,2048,8192; tap k in bits [4k+3:4k]
  localparam logic [27:0] TAP_LOG2_DEF = {4'hD, 4'hB, 4'h9, 4'h8, 4'h6, 4'h4, 4'h2};
  localparam logic [2:0]  CS_EXT       = 3'h7;

  // ---------------------------------------------------------------------------
  // register map, byte addresses
  // ---------------------------------------------------------------------------
  localparam int          ADDR_W       = 5;
  localparam logic [4:0]  OFS_CTRL     = 5'h00;
  localparam logic [4:0]  OFS_COUNT    = 5'h04;
  localparam logic [4:0]  OFS_RELOAD   = 5'h08;
  localparam logic [4:0]  OFS_STATUS   = 5'h0C;
  localparam logic [4:0]  OFS_MASK     = 5'h10;

  // control field positions
  localparam int          CTRL_RSEL_BIT = 7;
  localparam int          CTRL_EDGE_BIT = 3;
  localparam int          CTRL_CS_LSB   = 0;
  // status and mask field position
  localparam int          OVF_BIT       = 0;

  // bus responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // control register contents
  typedef struct packed {
    logic       reload_select;
    logic       edge_rise;
    logic [2:0] clock_select;
  } ebt_ctrl_s;

  localparam ebt_ctrl_s   CTRL_RST     = '{reload_select: 1'b0, edge_rise: 1'b1,
                                           clock_select: 3'h0};
  localparam logic        FLAG_RST     = 1'b0;

endpackage : ebt_pkg

// ===== rtl/ebt_prescaler.sv
// free running prescaler giving one-cycle ticks at seven internal divisions
`timescale 1ns/1ns
module ebt_prescaler #(
  parameter int          PRE_W    = ebt_pkg::PRE_W,
  parameter logic [27:0] TAP_LOG2 = ebt_pkg::TAP_LOG2_DEF
) (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  output logic      [ebt_pkg::N_TAPS-1:0]   tap_tick
);

  logic [PRE_W-1:0] pre;

  // ---------------------------------------------------------------------------
  // low-bit mask for a division of 2**e
  // ---------------------------------------------------------------------------
  function automatic logic [PRE_W-1:0] ebt_tap_mask(input logic [3:0] e);
    logic [PRE_W-1:0] m;
    m = '0;
    for (int i = 0; i < PRE_W; i++) begin
      m[i] = (i < int'(e));
    end
    return m;
  endfunction : ebt_tap_mask

  // base counter, wraps freely
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre <= '0;
    end else begin
      pre <= pre + 1'b1;
    end
  end

  // each tap fires when its low bits are all ones
  for (genvar k = 0; k < ebt_pkg::N_TAPS; k++) begin : g_tap
    assign tap_tick[k] = &(pre | ~ebt_tap_mask(TAP_LOG2[4*k +: 4]));
  end

  // the fastest tap fires once in every four cycles
  chk_tap_spacing: assert property (@(posedge clk) disable iff (!rst_n)
    tap_tick[0] |=> !tap_tick[0] [*3] ##1 tap_tick[0])
    else $error("fastest prescaler tap not spaced by four cycles");

endmodule : ebt_prescaler

// ===== rtl/ebt_timer.sv
// eight-bit reload timer with prescaler, event input, interrupt and axi4-lite slave
//
// Behaviour
// - one 8-bit counter that steps up by one per selected count tick
// - reset clears counter and reload select, interval counting starts at once
// - a tick while the counter holds all-ones is an overflow, not a step
// - in reload mode an overflow loads the reload value and counting continues
// - clock select all ones makes external input edges the count source
// - software picks one of seven internal sources or the external input
// - every overflow sets the flag, whatever the mode; irq follows only while the mask bit is set
// - reload select 0: count 00 to FF, then wrap to 00
// - reload select 1: count from reload value to FF, reload after overflow
// - internal taps are the clock divided by 4,16,64,256,512,2048,8192
// - event mode counts rising or falling edges; source supplies clean edges
`timescale 1ns/1ns
module ebt_timer #(
  parameter logic [27:0] TAP_LOG2 = ebt_pkg::TAP_LOG2_DEF
) (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  // axi4-lite write address
  input  wire logic [ebt_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  // axi4-lite write response
  output logic      [1:0]                   s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  // axi4-lite read address
  input  wire logic [ebt_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  // axi4-lite read data
  output logic      [31:0]                  s_axi_rdata,
  output logic      [1:0]                   s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  // external event source and interrupt
  input  wire logic                         event_input_pin,
  output logic                              irq
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  ebt_pkg::ebt_ctrl_s          timer_mode_control;
  logic [ebt_pkg::CNT_W-1:0]   count_value;
  logic [ebt_pkg::CNT_W-1:0]   reload_value;
  logic                        ovf_flag;
  logic                        ovf_mask;
  logic                        pin_q;

  // write channel holding registers
  logic                        aw_held;
  logic [ebt_pkg::ADDR_W-1:0]  aw_addr;
  logic                        w_held;
  logic [7:0]                  w_byte;
  logic                        w_lane0;

  // ---------------------------------------------------------------------------
  // count sources
  // ---------------------------------------------------------------------------
  logic [ebt_pkg::N_TAPS-1:0]  tap_tick;
  logic                        pin_rise;
  logic                        pin_fall;
  logic                        edge_hit;
  logic                        sel_ext;
  logic [ebt_pkg::N_TAPS:0]    src_vec;
  logic                        count_tick;
  logic                        ovf_hit;
  logic [ebt_pkg::CNT_W-1:0]   next_count;

  ebt_prescaler #(
    .PRE_W    (ebt_pkg::PRE_W),
    .TAP_LOG2 (TAP_LOG2)
  ) u_prescaler (
    .clk      (clk),
    .rst_n    (rst_n),
    .tap_tick (tap_tick)
  );

  // edge detection on the event pin, already synchronous to clk
  assign pin_rise   = event_input_pin & ~pin_q;
  assign pin_fall   = ~event_input_pin & pin_q;
  assign edge_hit   = timer_mode_control.edge_rise ? pin_rise : pin_fall;
  assign sel_ext    = (timer_mode_control.clock_select == ebt_pkg::CS_EXT);
  // source mux, seven taps below the pin edge at index seven
  assign src_vec    = {edge_hit, tap_tick};
  assign count_tick = src_vec[timer_mode_control.clock_select];

  // ---------------------------------------------------------------------------
  // counter step, overflow and reload
  // ---------------------------------------------------------------------------
  assign ovf_hit    = count_tick && (count_value == ebt_pkg::COUNT_MAX);
  assign next_count = !count_tick ? count_value
                    : !ovf_hit    ? count_value + 1'b1
                    : timer_mode_control.reload_select ? reload_value
                    : ebt_pkg::COUNT_RST;

  // pin history and counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_q       <= event_input_pin; // no false edge after reset
      count_value <= ebt_pkg::COUNT_RST;
    end else begin
      pin_q       <= event_input_pin;
      count_value <= next_count;
    end
  end

  // ---------------------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------------------
  function automatic logic ebt_mapped(input logic [ebt_pkg::ADDR_W-1:0] a);
    return (a == ebt_pkg::OFS_CTRL)   || (a == ebt_pkg::OFS_COUNT) ||
           (a == ebt_pkg::OFS_RELOAD) || (a == ebt_pkg::OFS_STATUS) ||
           (a == ebt_pkg::OFS_MASK);
  endfunction : ebt_mapped

  logic do_write;
  logic wr_ctrl;
  logic wr_reload;
  logic wr_status;
  logic wr_mask;
  logic ovf_clear;
  logic next_ovf_flag;
  logic ar_take;
  logic [31:0] rd_mux;

  // a write commits once address and data are both held
  assign do_write  = aw_held && w_held && !s_axi_bvalid;
  assign wr_ctrl   = do_write && w_lane0 && (aw_addr == ebt_pkg::OFS_CTRL);
  assign wr_reload = do_write && w_lane0 && (aw_addr == ebt_pkg::OFS_RELOAD);
  assign wr_status = do_write && w_lane0 && (aw_addr == ebt_pkg::OFS_STATUS);
  assign wr_mask   = do_write && w_lane0 && (aw_addr == ebt_pkg::OFS_MASK);

  // overflow flag: set wins over a write-one clear in the same cycle
  assign ovf_clear     = wr_status && w_byte[ebt_pkg::OVF_BIT];
  assign next_ovf_flag = ovf_hit | (ovf_flag & ~ovf_clear);

  // level interrupt while an unmasked flag stands
  assign irq = ovf_flag & ovf_mask;

  // ---------------------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timer_mode_control <= ebt_pkg::CTRL_RST;
      reload_value       <= ebt_pkg::RELOAD_RST;
      ovf_flag           <= ebt_pkg::FLAG_RST;
      ovf_mask           <= ebt_pkg::FLAG_RST;
    end else begin
      if (wr_ctrl) begin
        timer_mode_control.reload_select <= w_byte[ebt_pkg::CTRL_RSEL_BIT];
        timer_mode_control.edge_rise     <= w_byte[ebt_pkg::CTRL_EDGE_BIT];
        timer_mode_control.clock_select  <= w_byte[ebt_pkg::CTRL_CS_LSB +: 3];
      end
      if (wr_reload) begin
        reload_value <= w_byte;
      end
      if (wr_mask) begin
        ovf_mask <= w_byte[ebt_pkg::OVF_BIT];
      end
      ovf_flag <= next_ovf_flag;
    end
  end

  // ---------------------------------------------------------------------------
  // axi4-lite write path
  // ---------------------------------------------------------------------------
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  // hold address and data in either order, answer after both
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held      <= 1'b0;
      aw_addr      <= '0;
      w_held       <= 1'b0;
      w_byte       <= 8'h00;
      w_lane0      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ebt_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= ebt_mapped(aw_addr) ? ebt_pkg::RESP_OKAY
                                            : ebt_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // axi4-lite read path
  // ---------------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_take       = s_axi_arvalid && s_axi_arready;

  // read data selection, unused bits read zero
  assign rd_mux =
      (s_axi_araddr == ebt_pkg::OFS_CTRL)   ?
        {24'h000000, timer_mode_control.reload_select, 3'h0,
         timer_mode_control.edge_rise, timer_mode_control.clock_select} :
      (s_axi_araddr == ebt_pkg::OFS_COUNT)  ? {24'h000000, count_value}  :
      (s_axi_araddr == ebt_pkg::OFS_RELOAD) ? {24'h000000, reload_value} :
      (s_axi_araddr == ebt_pkg::OFS_STATUS) ? {31'h00000000, ovf_flag}   :
      (s_axi_araddr == ebt_pkg::OFS_MASK)   ? {31'h00000000, ovf_mask}   :
      32'h00000000;

  // read answer one cycle after the address is taken
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= ebt_pkg::RESP_OKAY;
    end else begin
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= ebt_mapped(s_axi_araddr) ? ebt_pkg::RESP_OKAY
                                                 : ebt_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // a tick below all-ones adds exactly one
  chk_count_step: assert property (
    count_tick && (count_value != ebt_pkg::COUNT_MAX)
      |=> count_value == $past(count_value) + 8'h01)
    else $error("counter did not step by one on a tick");

  // reset leaves the counter at zero and interval mode selected
  chk_reset_clear: assert property (@(posedge clk) disable iff (1'b0)
    !rst_n |=> (count_value == ebt_pkg::COUNT_RST) &&
               !timer_mode_control.reload_select)
    else $error("reset did not clear counter or reload select");

  // a tick at all-ones raises the overflow flag and does not step to zero+1
  chk_ovf_point: assert property (
    ovf_hit |=> ovf_flag && (count_value != 8'h00 ||
                             !$past(timer_mode_control.reload_select) ||
                             $past(reload_value) == 8'h00))
    else $error("overflow at all-ones not registered");

  // reload mode loads the software value on overflow
  chk_reload_load: assert property (
    ovf_hit && timer_mode_control.reload_select
      |=> count_value == $past(reload_value))
    else $error("reload value not loaded after overflow");

  // interval mode wraps to zero on overflow
  chk_wrap_zero: assert property (
    ovf_hit && !timer_mode_control.reload_select |=> count_value == 8'h00)
    else $error("counter did not wrap to zero");

  // in event mode the counter only moves on a selected pin edge
  chk_ext_source: assert property (
    sel_ext && !edge_hit |=> $stable(count_value))
    else $error("counter moved without a pin edge in event mode");

  // a rising edge in event mode moves the counter or overflows
  chk_edge_count: assert property (
    sel_ext && timer_mode_control.edge_rise && pin_rise
      |=> $past(ovf_hit) ? ovf_flag : !$stable(count_value))
    else $error("rising pin edge not counted");

  // every internal source tick lines up with the fastest tap
  chk_int_source: assert property (
    count_tick && !sel_ext |-> tap_tick[0])
    else $error("internal count tick off the prescaler grid");

  // an overflow with the mask open drives the interrupt next cycle
  chk_irq_raise: assert property (
    ovf_hit && ovf_mask && !wr_mask |=> irq)
    else $error("interrupt not raised on overflow");

  // the flag holds until a one is written to it
  chk_flag_sticky: assert property (
    ovf_flag && !ovf_clear |=> ovf_flag)
    else $error("overflow flag dropped without a clear");

  // the bus answers a read one cycle after taking it
  chk_read_answer: assert property (
    ar_take |=> s_axi_rvalid)
    else $error("read not answered one cycle after address");

  // a falling edge counts when falling edges are selected
  chk_fall_count: assert property (
    sel_ext && !timer_mode_control.edge_rise && pin_fall
      |=> $past(ovf_hit) ? ovf_flag : !$stable(count_value))
    else $error("falling pin edge not counted");

  // an overflow and a clear in one cycle leave the flag set
  chk_set_wins: assert property (
    ovf_hit && ovf_clear |=> ovf_flag)
    else $error("clear beat a simultaneous overflow");

  // without a tick the counter holds its value
  chk_count_hold: assert property (
    !count_tick |=> $stable(count_value))
    else $error("counter moved without a count tick");

  // a committed write is answered in the next cycle
  chk_write_answer: assert property (
    do_write |=> s_axi_bvalid)
    else $error("write not answered after commit");

  // main scenarios
  cov_reload_ovf: cover property (ovf_hit && timer_mode_control.reload_select);
  cov_ext_count:  cover property (sel_ext && edge_hit);
  cov_irq_on:     cover property ($rose(irq));
  cov_set_clear:  cover property (ovf_hit && ovf_clear);
  cov_fall_count: cover property (sel_ext && !timer_mode_control.edge_rise && pin_fall);

endmodule : ebt_timer

// ===== dv/ebt_event_src.sv
// event source model that drives the timer's external count input
`timescale 1ns/1ns
module ebt_event_src (
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic [9:0] n_tog,
  input  wire logic [2:0] hold,
  output logic            busy,
  output logic            event_input_pin
);
  logic [9:0] left;
  logic [2:0] cnt;

  initial begin
    event_input_pin = 1'b0;
    left = 10'h000;
    cnt = 3'h0;
  end

  // one clean edge per toggle, each level stands hold+1 cycles
  always @(posedge clk) begin
    if (start) begin
      left <= n_tog;
      cnt <= 3'h0;
    end else if (left != 10'h000) begin
      if (cnt == hold) begin
        event_input_pin <= ~event_input_pin;
        left <= left - 10'h001;
        cnt <= 3'h0;
      end else begin
        cnt <= cnt + 3'h1;
      end
    end
  end

  assign busy = start || (left != 10'h000);
endmodule : ebt_event_src

// ===== dv/ebt_timer_bench.sv
// self-checking bench of the eight-bit reload timer
`timescale 1ns/1ns
module ebt_timer_bench;
  localparam logic [27:0] TAPS = {4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h2};
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, start;
  logic        awready, wready, bvalid, arready, rvalid, irq, irq_q, pin, ev_busy;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, lfsr;
  logic [1:0]  bresp, rresp;
  logic [9:0]  n_tog;
  logic [2:0]  hold;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  int          error_cnt, n_compared, cyc, rise_at;

  ebt_timer #(.TAP_LOG2(TAPS)) DUT (.clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .event_input_pin(pin), .irq(irq));

  ebt_event_src src (.clk(clk), .start(start), .n_tog(n_tog), .hold(hold), .busy(ev_busy),
    .event_input_pin(pin));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test

  // bus write: address and data offered together, each dropped when taken
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] er = ebt_pkg::RESP_OKAY);
    bq.push_back(er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1; // stays high between writes
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] ev,
                    input logic [1:0] er = ebt_pkg::RESP_OKAY);
    rq.push_back({er, 24'h000000, ev});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1; // stays high between reads
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
  endtask : rd

  // responses are compared against the oldest noted expectation
  always @(posedge clk) begin
    if (bvalid && bready) check({32'h0, bresp}, {32'h0, bq.pop_front()});
    if (rvalid && rready) check({rresp, rdata}, rq.pop_front());
  end

  // cycle stamp of each interrupt rise
  always @(posedge clk) begin
    cyc <= rst_n ? cyc + 1 : 0;
    irq_q <= irq;
    if (irq && !irq_q) rise_at <= cyc;
  end

  task automatic wait_irq;
    int t;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (irq !== 1'b1 && t < 5000);
    check({33'h0, irq}, 34'h1);
    @(posedge clk);
  endtask : wait_irq

  // cycles between two overflows, flag cleared in between
  task automatic period(input int exp);
    int t1;
    wr(ebt_pkg::OFS_STATUS, 32'h1);
    wait_irq();
    wr(ebt_pkg::OFS_STATUS, 32'h1);
    wait_irq();
    t1 = rise_at;
    wr(ebt_pkg::OFS_STATUS, 32'h1);
    wait_irq();
    check(34'(rise_at - t1), 34'(exp));
  endtask : period

  task automatic toggles(input int n);
    n_tog <= 10'(n);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    while (ev_busy) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask : toggles

  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(ebt_pkg::OFS_CTRL, 8'h08);
    rd(ebt_pkg::OFS_RELOAD, 8'h00);
    rd(ebt_pkg::OFS_STATUS, 8'h00);
    rd(ebt_pkg::OFS_MASK, 8'h00);
  endtask : do_reset

  // event counting with random reload value and level hold
  task automatic ev_test(input logic p);
    logic [7:0] r;
    int k;
    lfsr = lfsr_next(lfsr);
    r = lfsr[7:0] % 8'hFE;
    hold <= lfsr[10:8] & 3'h3;
    wr(ebt_pkg::OFS_RELOAD, {24'h0, r});
    wr(ebt_pkg::OFS_CTRL, {24'h0, 1'b1, 3'h0, p, 3'h7});
    wr(ebt_pkg::OFS_STATUS, 32'h1);
    k = 0;
    while (irq !== 1'b1 && k < 600) begin
      toggles(1);
      k++;
    end
    check({33'h0, irq}, 34'h1);
    toggles(1);
    rd(ebt_pkg::OFS_COUNT, r);
    toggles(1);
    rd(ebt_pkg::OFS_COUNT, r + 8'h01);
    wr(ebt_pkg::OFS_STATUS, 32'h1);
    toggles(2 * (254 - int'(r)));
    wr(ebt_pkg::OFS_COUNT, 32'h0);
    rd(ebt_pkg::OFS_COUNT, 8'hFF);
    rd(ebt_pkg::OFS_STATUS, 8'h00);
    toggles(2);
    rd(ebt_pkg::OFS_STATUS, 8'h01);
    rd(ebt_pkg::OFS_COUNT, r);
    check({33'h0, irq}, 34'h1);
    $display("test event edge=%0d done", p);
  endtask : ev_test

  initial begin
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, start} = 6'h00;
    awaddr = 5'h00;
    araddr = 5'h00;
    wdata = 32'h0;
    n_tog = 10'h000;
    hold = 3'h0;
    lfsr = 32'hA38E818A;
    error_cnt = 0;
    n_compared = 0;
    do_reset();
    wr(ebt_pkg::OFS_MASK, 32'h1);
    wait_irq();
    check({33'h0, rise_at > 1020 && rise_at < 1030}, 34'h1);
    period(1024);
    $display("test reset interval done");
    wr(ebt_pkg::OFS_RELOAD, 32'hFC);
    for (int cs = 0; cs < 7; cs++) begin
      wr(ebt_pkg::OFS_CTRL, 32'h80 | cs);
      period(4 * (1 << TAPS[4*cs +: 4]));
      // clears every third cycle sweep across the overflow phase
      if (cs == 0) repeat (16) wr(ebt_pkg::OFS_STATUS, 32'h1);
    end
    $display("test taps done");
    ev_test(1'b1);
    wr(ebt_pkg::OFS_MASK, 32'h0);
    check({33'h0, irq}, 34'h0);
    wr(ebt_pkg::OFS_MASK, 32'h1);
    check({33'h0, irq}, 34'h1);
    wr(ebt_pkg::OFS_STATUS, 32'h1);
    check({33'h0, irq}, 34'h0);
    rd(5'h14, 8'h00, ebt_pkg::RESP_SLVERR);
    wr(5'h18, 32'hFF, ebt_pkg::RESP_SLVERR);
    $display("test mask unmapped done");
    do_reset();
    wr(ebt_pkg::OFS_MASK, 32'h1);
    ev_test(1'b0);
    finish_test();
  end

  // watchdog
  initial begin
    #600000;
    error_cnt++;
    finish_test();
  end
endmodule : ebt_timer_bench
